// *** dv/gpio_debug_trace_config_sva.sv ***
`default_nettype none
module gpio_debug_trace_config_sva #(
  parameter int TRACE_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [TRACE_W-1:0] pcTraceData,
  input wire logic [TRACE_W-1:0] baseband_debug_output,
  input wire logic [TRACE_W-1:0] traceChannelOut,
  input wire logic debugRequest,
  input wire logic debugPinOverride,
  input wire logic regulatorEnable,
  input wire logic portAPinSevenGpioOut,
  input wire logic portAPinSevenGpioOeN,
  input wire logic port_a_pin_seven_out,
  input wire logic port_a_pin_seven_oe_n,
  input wire logic regulatorOverrideActive,
  input wire logic global_pad_strength
);
  localparam logic [31:0] CFG = gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_ADDR;
  localparam logic [31:0] STAT = gpio_debug_trace_config_pkg::DEBUG_PIN_STATUS_ADDR;
  localparam logic [31:0] TRC = gpio_debug_trace_config_pkg::TRACE_CHANNEL_SELECT_ADDR;
  logic live_ff, wrPend_ff, sel_ff, taken;
  logic [31:0] wrAddr_ff, cfg_ff;
  logic [TRACE_W-1:0] expSrc;
  assign taken = hsel && hready && htrans[1];
  assign expSrc = sel_ff ? pcTraceData : baseband_debug_output;
  // Shadow of the register writes seen on the bus
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_ff <= 1'b0;
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 32'h0;
    end else begin
      live_ff <= 1'b1;
      wrPend_ff <= taken && hwrite;
      wrAddr_ff <= haddr;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) cfg_ff <= gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_RST;
    else if (wrPend_ff && wrAddr_ff == CFG) cfg_ff <= hwdata & 32'h00000038;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) sel_ff <= 1'b0;
    else if (wrPend_ff && wrAddr_ff == TRC) sel_ff <= hwdata[0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_cfgRead; taken && !hwrite && haddr == CFG; endsequence
  sequence s_statRead; taken && !hwrite && haddr == STAT; endsequence
  property p_cfg_read; s_cfgRead |=> hrdata == cfg_ff; endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
  property p_stat_rsvd; s_statRead |=> hrdata[31:4] == 28'h0 && !hrdata[2]; endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved set");
  property p_trace; live_ff |-> traceChannelOut == $past(expSrc); endproperty
  a_trace: assert property (p_trace) else $error("trace channel wrong source");
  property p_pad; global_pad_strength == cfg_ff[3]; endproperty
  a_pad: assert property (p_pad) else $error("pad strength wrong");
  property p_reg_act; regulatorOverrideActive == !cfg_ff[4]; endproperty
  a_reg_act: assert property (p_reg_act) else $error("regulator override wrong");
  property p_pin_reg;
    regulatorOverrideActive |-> port_a_pin_seven_out == regulatorEnable && !port_a_pin_seven_oe_n;
  endproperty
  a_pin_reg: assert property (p_pin_reg) else $error("pin seven not regulator");
  property p_pin_gpio;
    !regulatorOverrideActive |-> port_a_pin_seven_out == portAPinSevenGpioOut
      && port_a_pin_seven_oe_n == portAPinSevenGpioOeN;
  endproperty
  a_pin_gpio: assert property (p_pin_gpio) else $error("pin seven not gpio");
  property p_dbg_cause; $rose(debugPinOverride) |-> $past(debugRequest) && !$past(cfg_ff[5]);
  endproperty
  a_dbg_cause: assert property (p_dbg_cause) else $error("debug override uncaused");
  property p_dbg_hold; debugPinOverride && debugRequest |=> debugPinOverride; endproperty
  a_dbg_hold: assert property (p_dbg_hold) else $error("debug override dropped");
  property p_dbg_grant; live_ff && debugRequest && !cfg_ff[5] |=> debugPinOverride; endproperty
  a_dbg_grant: assert property (p_dbg_grant) else $error("debug override missing");
  property p_dbg_drop; !debugRequest |=> !debugPinOverride; endproperty
  a_dbg_drop: assert property (p_dbg_drop) else $error("debug override stuck");
endmodule
`default_nettype wire

// *** dv/gpio_debug_trace_config_tb.sv ***
`default_nettype none
module gpio_debug_trace_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TRACE_W = 8;
  localparam logic [31:0] CFG = gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_ADDR;
  localparam logic [31:0] STAT = gpio_debug_trace_config_pkg::DEBUG_PIN_STATUS_ADDR;
  localparam logic [31:0] TRC = gpio_debug_trace_config_pkg::TRACE_CHANNEL_SELECT_ADDR;
  logic [31:0] modelOfAddr [4] = '{CFG, STAT, TRC, 32'h0000bc08};
  logic sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, selM, bootM;
  logic [31:0] haddr, hwdata, hrdata, seed, rd, cfgM;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [TRACE_W-1:0] pcTraceData, baseband_debug_output, traceChannelOut;
  logic debugRequest, debugger_forced_active, serial_wire_enabled, debugPinOverride;
  logic regulatorEnable, portAPinSevenGpioOut, portAPinSevenGpioOeN, regulatorOverrideActive;
  logic port_a_pin_seven_out, port_a_pin_seven_oe_n, global_pad_strength;
  logic boot_select_pin_low_active;
  int nFail = 0;
  int numChecks = 0;
  assign hready = hreadyout;
  gpio_debug_trace_config #(.TRACE_W(TRACE_W)) i_gpio_debug_trace_config (
    .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pcTraceData(pcTraceData),
    .baseband_debug_output(baseband_debug_output), .traceChannelOut(traceChannelOut),
    .debugRequest(debugRequest), .debugger_forced_active(debugger_forced_active),
    .serial_wire_enabled(serial_wire_enabled), .debugPinOverride(debugPinOverride),
    .regulatorEnable(regulatorEnable), .portAPinSevenGpioOut(portAPinSevenGpioOut),
    .portAPinSevenGpioOeN(portAPinSevenGpioOeN), .port_a_pin_seven_out(port_a_pin_seven_out),
    .port_a_pin_seven_oe_n(port_a_pin_seven_oe_n),
    .regulatorOverrideActive(regulatorOverrideActive),
    .global_pad_strength(global_pad_strength),
    .boot_select_pin_low_active(boot_select_pin_low_active));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] modelOf(input logic [31:0] a);
    case (a)
      CFG: return cfgM;
      STAT: return {28'h0, bootM, 1'b0, debugger_forced_active, serial_wire_enabled};
      TRC: return {31'h0, selM};
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic phase(output logic [31:0] r);
    logic rdy;
    do begin
      @(negedge sys_clk);
      r = hrdata;
      rdy = hreadyout;
      @(posedge sys_clk);
    end while (rdy !== 1'b1);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= gpio_debug_trace_config_pkg::HTRANS_NONSEQ;
    hsize <= gpio_debug_trace_config_pkg::HSIZE_WORD;
    phase(rd);
    hsel <= 1'b0;
    htrans <= gpio_debug_trace_config_pkg::HTRANS_IDLE;
    hwdata <= d;
    phase(rd);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    if (a == CFG) cfgM = d & 32'h00000038;
    if (a == TRC) selM = d[0];
  endtask
  task automatic chkReg(input logic [31:0] a);
    ahb(1'b0, a, 32'h0);
    chk(rd, modelOf(a));
  endtask
  task automatic randIn();
    void'(rnd());
    pcTraceData <= seed[TRACE_W-1:0];
    baseband_debug_output <= seed[31 -: TRACE_W];
    regulatorEnable <= seed[16];
    portAPinSevenGpioOut <= seed[17];
    portAPinSevenGpioOeN <= seed[18];
  endtask
  task automatic chkPorts(input logic dbgExp);
    @(negedge sys_clk);
    chk(32'(global_pad_strength), 32'(cfgM[3]));
    chk(32'(regulatorOverrideActive), 32'(!cfgM[4]));
    chk({30'h0, port_a_pin_seven_oe_n, port_a_pin_seven_out},
        cfgM[4] ? {30'h0, portAPinSevenGpioOeN, portAPinSevenGpioOut}
                : {31'h0, regulatorEnable});
    chk(32'(traceChannelOut), 32'(selM ? pcTraceData : baseband_debug_output));
    chk(32'(debugPinOverride), 32'(dbgExp));
    chk(32'(hresp), 32'(gpio_debug_trace_config_pkg::HRESP_OKAY));
    @(posedge sys_clk);
  endtask
  task automatic doReset(input logic pinLow);
    reset_n <= 1'b0;
    boot_select_pin_low_active <= !pinLow;
    debugRequest <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    cfgM = gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_RST;
    selM = 1'b0;
    bootM = pinLow;
    repeat (2) @(posedge sys_clk);
    // Pin moves after capture; status must keep the captured level
    boot_select_pin_low_active <= pinLow;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    nFail++;
    test_done();
  end
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {debugger_forced_active, serial_wire_enabled} = '0;
    {pcTraceData, baseband_debug_output, regulatorEnable} = '0;
    {portAPinSevenGpioOut, portAPinSevenGpioOeN} = '0;
    seed = 32'h00003529;
    doReset(1'b0);
    foreach (modelOfAddr[i]) chkReg(modelOfAddr[i]);
    chkPorts(1'b0);
    $display("reset values test done");
    for (int i = 0; i < 8; i++) begin
      randIn();
      wr(CFG, 32'(i) << 3);
      chkReg(CFG);
      chkPorts(1'b0);
    end
    $display("configuration test done");
    for (int i = 1; i >= 0; i--) begin
      wr(TRC, 32'(i));
      randIn();
      chkReg(TRC);
      chkPorts(1'b0);
    end
    $display("trace select test done");
    for (int i = 0; i < 4; i++) begin
      {debugger_forced_active, serial_wire_enabled} <= 2'(i);
      wr(STAT, 32'hffffffff);
      wr(32'h0000bc08, 32'hffffffff);
      repeat (2) @(posedge sys_clk);
      chkReg(STAT);
      chkReg(CFG);
    end
    $display("status test done");
    wr(CFG, 32'h0);
    debugRequest <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chkPorts(1'b1);
    wr(CFG, 32'h00000020);
    chkPorts(1'b1);
    debugRequest <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chkPorts(1'b0);
    debugRequest <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chkPorts(1'b0);
    $display("debug override test done");
    doReset(1'b1);
    chkReg(STAT);
    chkReg(CFG);
    $display("boot capture test done");
    test_done();
  end
endmodule
bind gpio_debug_trace_config gpio_debug_trace_config_sva #(.TRACE_W(TRACE_W)) i_sva (
  .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .pcTraceData(pcTraceData), .baseband_debug_output(baseband_debug_output),
  .traceChannelOut(traceChannelOut), .debugRequest(debugRequest),
  .debugPinOverride(debugPinOverride), .regulatorEnable(regulatorEnable),
  .portAPinSevenGpioOut(portAPinSevenGpioOut), .portAPinSevenGpioOeN(portAPinSevenGpioOeN),
  .port_a_pin_seven_out(port_a_pin_seven_out), .port_a_pin_seven_oe_n(port_a_pin_seven_oe_n),
  .regulatorOverrideActive(regulatorOverrideActive),
  .global_pad_strength(global_pad_strength));
`default_nettype wire

// *** logic/boot_pin_capture.sv ***
`default_nettype none
module boot_pin_capture (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic boot_select_pin_low_active,
  output logic sampledBootPinState,
  output logic captureDone
);

  logic captured_ff;
  logic bootState_ff;

  // Single capture on the first edge after reset release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      captured_ff <= 1'b0;
    end else begin
      captured_ff <= 1'b1;
    end
  end

  // Pin is active low: a low level reads as 1
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bootState_ff <= 1'b0;
    end else if (!captured_ff) begin
      bootState_ff <= ~boot_select_pin_low_active; // RULE8
    end
  end

  assign sampledBootPinState = bootState_ff;
  assign captureDone = captured_ff;

endmodule
`default_nettype wire

// *** logic/gpio_debug_trace_config.sv ***
// Behaviour
// RULE1: Trace select bit 0 high routes PC trace, low routes baseband debug.
// RULE2: Software keeps trace select bits 31 to 1 at zero.
// RULE3: Debug disable bit 5 blocks debug override unless debug already active.
// RULE4: Bit 4 low lets regulator enable drive port A pin 7; high suppresses.
// RULE5: Bit 3 globally enables stronger drive on all pads.
// RULE6: Debug configuration at 0xbc00, resets to 0x00000010.
// RULE7: Software keeps debug configuration bits 31:6 and 2:0 at zero.
// RULE8: Boot pin captured once at reset end; status bit 3 reads 1 if low.
// RULE9: Status bit 1 shows debugger cable forcing the debug interface active.
// RULE10: Status bit 0 shows serial-wire interface enabled by debug port.
// RULE11: Debug status at 0xbc04, reads zero after reset except sampled bits.
// RULE12: Status writes ignored; status reserved bits read zero.
//
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none
module gpio_debug_trace_config #(
  parameter int TRACE_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Trace channel sources and shared channel
  input wire logic [TRACE_W-1:0] pcTraceData,
  input wire logic [TRACE_W-1:0] baseband_debug_output,
  output logic [TRACE_W-1:0] traceChannelOut,
  // Debug interface
  input wire logic debugRequest,
  input wire logic debugger_forced_active,
  input wire logic serial_wire_enabled,
  output logic debugPinOverride,
  // Regulator enable on port A pin 7
  input wire logic regulatorEnable,
  input wire logic portAPinSevenGpioOut,
  input wire logic portAPinSevenGpioOeN,
  output logic port_a_pin_seven_out,
  output logic port_a_pin_seven_oe_n,
  output logic regulatorOverrideActive,
  // Pads and boot strap
  output logic global_pad_strength,
  input wire logic boot_select_pin_low_active
);

  gpio_debug_trace_config_pkg::debugCfg_s cfg_ff;
  gpio_debug_trace_config_pkg::debugStatus_s status_ff;
  gpio_debug_trace_config_pkg::busTarget_s target;
  gpio_debug_trace_config_pkg::busTarget_s pend_ff;
  gpio_debug_trace_config_pkg::busPhase_e phase_ff;
  gpio_debug_trace_config_pkg::busPhase_e nxt_phase;

  logic traceSel_ff;
  logic debugActive_ff;
  logic nxt_debugActive;
  logic [TRACE_W-1:0] traceOut_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic [31:0] cfgWord;
  logic [31:0] statusWord;
  logic [31:0] traceWord;
  logic [3:0] lanes;
  logic addrPhase;
  logic writeLow;
  logic cfgWrite;
  logic traceWrite;
  logic bootState;
  logic bootDone;

  // Boot strap capture
  boot_pin_capture i_boot_pin_capture (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .boot_select_pin_low_active(boot_select_pin_low_active),
    .sampledBootPinState(bootState),
    .captureDone(bootDone)
  );

  // Zero wait state slave
  assign hreadyout = 1'b1;
  assign hresp = gpio_debug_trace_config_pkg::HRESP_OKAY;

  assign addrPhase = hsel && hready && htrans[1];

  // Byte lanes from size and low address bits
  always_comb begin
    lanes = 4'h0;
    case (hsize)
      gpio_debug_trace_config_pkg::HSIZE_BYTE: begin
        lanes = 4'h1 << haddr[1:0];
      end
      gpio_debug_trace_config_pkg::HSIZE_HALF: begin
        lanes = haddr[1] ? 4'hc : 4'h3;
      end
      gpio_debug_trace_config_pkg::HSIZE_WORD: begin
        lanes = 4'hf;
      end
      default: begin
        lanes = 4'h0;
      end
    endcase
  end

  // Address decode on the word address
  always_comb begin
    target.isConfig = ({haddr[31:2], 2'h0} ==
      gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_ADDR);
    target.isStatus = ({haddr[31:2], 2'h0} ==
      gpio_debug_trace_config_pkg::DEBUG_PIN_STATUS_ADDR);
    target.isTrace = ({haddr[31:2], 2'h0} ==
      gpio_debug_trace_config_pkg::TRACE_CHANNEL_SELECT_ADDR);
    target.lanes = lanes;
  end

  // Bus phase tracking
  always_comb begin
    nxt_phase = gpio_debug_trace_config_pkg::PHASE_IDLE;
    if (addrPhase) begin
      if (hwrite) begin
        nxt_phase = gpio_debug_trace_config_pkg::PHASE_WRITE;
      end else begin
        nxt_phase = gpio_debug_trace_config_pkg::PHASE_READ;
      end
    end else if (!hready) begin
      nxt_phase = phase_ff;
    end
  end

  // Phase register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= gpio_debug_trace_config_pkg::PHASE_IDLE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Address phase capture for the following data phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_ff <= '0;
    end else if (hready) begin
      pend_ff <= addrPhase ? target : '0;
    end
  end

  // Data phase decode; only the low byte holds fields
  always_comb begin
    writeLow = 1'b0;
    case (phase_ff)
      gpio_debug_trace_config_pkg::PHASE_IDLE: begin
        writeLow = 1'b0;
      end
      gpio_debug_trace_config_pkg::PHASE_WRITE: begin
        writeLow = pend_ff.lanes[0];
      end
      gpio_debug_trace_config_pkg::PHASE_READ: begin
        writeLow = 1'b0;
      end
      default: begin
        writeLow = 1'b0;
      end
    endcase
  end

  // Per-register write strobes for the data phase end edge
  assign cfgWrite = writeLow && pend_ff.isConfig;
  assign traceWrite = writeLow && pend_ff.isTrace;

  // Debug configuration register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff.debugOverrideDisable <=
        gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_RST[
          gpio_debug_trace_config_pkg::DEBUG_OVERRIDE_DISABLE_BIT]; // RULE6
      cfg_ff.regulatorOverrideDisable <=
        gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_RST[
          gpio_debug_trace_config_pkg::REGULATOR_OVERRIDE_DISABLE_BIT]; // RULE6
      cfg_ff.globalPadStrength <=
        gpio_debug_trace_config_pkg::DEBUG_PIN_CONFIG_RST[
          gpio_debug_trace_config_pkg::GLOBAL_PAD_STRENGTH_BIT]; // RULE6
    end else if (cfgWrite) begin
      cfg_ff.debugOverrideDisable <=
        hwdata[gpio_debug_trace_config_pkg::DEBUG_OVERRIDE_DISABLE_BIT];
      cfg_ff.regulatorOverrideDisable <=
        hwdata[gpio_debug_trace_config_pkg::REGULATOR_OVERRIDE_DISABLE_BIT];
      cfg_ff.globalPadStrength <=
        hwdata[gpio_debug_trace_config_pkg::GLOBAL_PAD_STRENGTH_BIT];
    end
  end

  // Trace channel select register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      traceSel_ff <= gpio_debug_trace_config_pkg::TRACE_CHANNEL_SELECT_RST[
        gpio_debug_trace_config_pkg::TRACE_SEL_BIT];
    end else if (traceWrite) begin
      traceSel_ff <= hwdata[gpio_debug_trace_config_pkg::TRACE_SEL_BIT];
    end
  end

  // Status snapshot; bus writes never reach it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_ff <= '0; // RULE11
    end else begin
      status_ff.sampledBootPinState <= bootState; // RULE8
      status_ff.debuggerForcedActive <= debugger_forced_active; // RULE9
      status_ff.serialWireEnabled <= serial_wire_enabled; // RULE10
    end
  end

  // Debug override latch: once active, disable cannot drop it
  always_comb begin
    nxt_debugActive = 1'b0;
    // Request gone: pins return on the next clock edge
    if (!debugRequest) begin
      nxt_debugActive = 1'b0;
    end else if (debugActive_ff) begin
      nxt_debugActive = 1'b1; // RULE3
    end else begin
      nxt_debugActive = !cfg_ff.debugOverrideDisable; // RULE3
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      debugActive_ff <= 1'b0;
    end else if (bootDone) begin
      debugActive_ff <= nxt_debugActive;
    end
  end

  assign debugPinOverride = debugActive_ff;

  // Shared trace channel
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      traceOut_ff <= '0;
    end else if (traceSel_ff) begin
      traceOut_ff <= pcTraceData; // RULE1
    end else begin
      traceOut_ff <= baseband_debug_output; // RULE1
    end
  end

  assign traceChannelOut = traceOut_ff;

  // Regulator enable override of port A pin 7
  assign regulatorOverrideActive = !cfg_ff.regulatorOverrideDisable; // RULE4

  // Pin is driven as an output while the override holds it
  always_comb begin
    if (regulatorOverrideActive) begin
      port_a_pin_seven_out = regulatorEnable; // RULE4
      port_a_pin_seven_oe_n = 1'b0; // RULE4
    end else begin
      port_a_pin_seven_out = portAPinSevenGpioOut;
      port_a_pin_seven_oe_n = portAPinSevenGpioOeN;
    end
  end

  // Global pad drive
  assign global_pad_strength = cfg_ff.globalPadStrength; // RULE5

  // Readback words; unused bits read zero
  always_comb begin
    cfgWord = '0;
    cfgWord[gpio_debug_trace_config_pkg::DEBUG_OVERRIDE_DISABLE_BIT] =
      cfg_ff.debugOverrideDisable;
    cfgWord[gpio_debug_trace_config_pkg::REGULATOR_OVERRIDE_DISABLE_BIT] =
      cfg_ff.regulatorOverrideDisable;
    cfgWord[gpio_debug_trace_config_pkg::GLOBAL_PAD_STRENGTH_BIT] =
      cfg_ff.globalPadStrength;
    if (cfgWrite) begin
      cfgWord[gpio_debug_trace_config_pkg::DEBUG_OVERRIDE_DISABLE_BIT] =
        hwdata[gpio_debug_trace_config_pkg::DEBUG_OVERRIDE_DISABLE_BIT];
      cfgWord[gpio_debug_trace_config_pkg::REGULATOR_OVERRIDE_DISABLE_BIT] =
        hwdata[gpio_debug_trace_config_pkg::REGULATOR_OVERRIDE_DISABLE_BIT];
      cfgWord[gpio_debug_trace_config_pkg::GLOBAL_PAD_STRENGTH_BIT] =
        hwdata[gpio_debug_trace_config_pkg::GLOBAL_PAD_STRENGTH_BIT];
    end
  end

  always_comb begin
    statusWord = '0; // RULE12
    statusWord[gpio_debug_trace_config_pkg::SAMPLED_BOOT_PIN_BIT] =
      status_ff.sampledBootPinState;
    statusWord[gpio_debug_trace_config_pkg::DEBUGGER_FORCED_BIT] =
      status_ff.debuggerForcedActive;
    statusWord[gpio_debug_trace_config_pkg::SERIAL_WIRE_BIT] =
      status_ff.serialWireEnabled;
  end

  always_comb begin
    traceWord = '0;
    traceWord[gpio_debug_trace_config_pkg::TRACE_SEL_BIT] = traceSel_ff;
    if (traceWrite) begin
      traceWord[gpio_debug_trace_config_pkg::TRACE_SEL_BIT] =
        hwdata[gpio_debug_trace_config_pkg::TRACE_SEL_BIT];
    end
  end

  // Read mux, sampled at the address phase edge
  always_comb begin
    nxt_hrdata = '0;
    case ({target.isConfig, target.isStatus, target.isTrace})
      3'b100: begin
        nxt_hrdata = cfgWord;
      end
      3'b010: begin
        nxt_hrdata = statusWord;
      end
      3'b001: begin
        nxt_hrdata = traceWord;
      end
      default: begin
        nxt_hrdata = '0; // Unmapped words read zero
      end
    endcase
  end

  // Read data stands for one data phase, then clears
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_ff <= '0;
    end else if (addrPhase && !hwrite) begin
      hrdata_ff <= nxt_hrdata;
    end else if (hready) begin
      hrdata_ff <= '0;
    end
  end

  assign hrdata = hrdata_ff;

endmodule
`default_nettype wire

// *** logic/gpio_debug_trace_config_pkg.sv ***
`default_nettype none
package gpio_debug_trace_config_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;

  // Register byte addresses
  localparam logic [31:0] DEBUG_PIN_CONFIG_ADDR = 32'h0000bc00;
  localparam logic [31:0] DEBUG_PIN_STATUS_ADDR = 32'h0000bc04;
  localparam logic [31:0] TRACE_CHANNEL_SELECT_ADDR = 32'h40004028;

  // Reset values
  localparam logic [31:0] DEBUG_PIN_CONFIG_RST = 32'h00000010;
  localparam logic [31:0] DEBUG_PIN_STATUS_RST = 32'h00000000;
  localparam logic [31:0] TRACE_CHANNEL_SELECT_RST = 32'h00000000;

  // Field positions
  localparam int TRACE_SEL_BIT = 0;
  localparam int DEBUG_OVERRIDE_DISABLE_BIT = 5;
  localparam int REGULATOR_OVERRIDE_DISABLE_BIT = 4;
  localparam int GLOBAL_PAD_STRENGTH_BIT = 3;
  localparam int SAMPLED_BOOT_PIN_BIT = 3;
  localparam int DEBUGGER_FORCED_BIT = 1;
  localparam int SERIAL_WIRE_BIT = 0;

  // AHB encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic debugOverrideDisable;
    logic regulatorOverrideDisable;
    logic globalPadStrength;
  } debugCfg_s;

  typedef struct packed {
    logic sampledBootPinState;
    logic debuggerForcedActive;
    logic serialWireEnabled;
  } debugStatus_s;

  typedef struct packed {
    logic isConfig;
    logic isStatus;
    logic isTrace;
    logic [3:0] lanes;
  } busTarget_s;

  typedef enum logic [2:0] {
    PHASE_IDLE = 3'b001,
    PHASE_WRITE = 3'b010,
    PHASE_READ = 3'b100
  } busPhase_e;

endpackage
`default_nettype wire
